// >>> logic/osa_regs.vh
`ifndef OSA_REGS_VH
`define OSA_REGS_VH

// Register offsets
`define OSA_ADDR_W 6
`define OSA_OFF_DEVICE_SETUP 6'h02
`define OSA_OFF_OVERSAMPLE_SETUP 6'h08
`define OSA_OFF_FILTER_STATUS 6'h30

// Reset values
`define OSA_RST_DEVICE_SETUP 8'h00
`define OSA_RST_OVERSAMPLE_SETUP 8'h00

// Field positions
`define OSA_EXT_CLK_BIT 5
`define OSA_PAD_HI 7
`define OSA_PAD_LO 5
`define OSA_RATIO_HI 3
`define OSA_RATIO_LO 0

// Ratio codes
`define OSA_PINS_SW_MODE 3'h7
`define OSA_RATIO_LG_MAX 4'h8

// Data widths
`define OSA_SAMPLE_W 16
`define OSA_CHANNELS 8
`define OSA_ACC_W 24

// Clock rate in MHz and internal sample clock frequencies, in units of 0.5 kHz
`define OSA_CLK_MHZ 100
`define OSA_PAD_F0_HKHZ 1600
`define OSA_PAD_F1_HKHZ 1506
`define OSA_PAD_F2_HKHZ 1422
`define OSA_PAD_F3_HKHZ 1347
`define OSA_PAD_F4_HKHZ 1280
`define OSA_PAD_F5_HKHZ 1219
`define OSA_PAD_F6_HKHZ 1164
`define OSA_PAD_F7_HKHZ 1113

// Sample period in clock cycles, rounded down
`define OSA_PAD_CYC(f) ((`OSA_CLK_MHZ * 2000) / (f))

`endif

// >>> logic/osa_fifo.v
`timescale 1ns/1ns
`default_nettype none

module osa_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire do_push;
  wire do_load;
  wire [AW:0] depth_w;

  // Full and empty from the word count
  assign depth_w = DEPTH[AW:0];
  assign in_ready = (count_r < depth_w);
  assign do_push = in_valid && in_ready;
  assign do_load = (!out_valid || out_ready) && (count_r != {(AW+1){1'b0}});

  // Storage, pointers and registered head word
  always @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (do_push) begin
        mem[wr_ptr_r] <= in_data;
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_load) begin
        out_data <= mem[rd_ptr_r];
        rd_ptr_r <= rd_ptr_r + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (do_push && !do_load) begin
        count_r <= count_r + 1'b1;
      end else if (!do_push && do_load) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/osa_filter.v
`timescale 1ns/1ns
`default_nettype none
`include "osa_regs.vh"

module osa_filter #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire [2:0] ratio_select_pins,
  input wire conversion_trigger,
  output reg busy_r,
  output reg conv_start_r,
  input wire conv_done,
  input wire [`OSA_CHANNELS*`OSA_SAMPLE_W-1:0] conv_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [`OSA_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output wire res_valid,
  input wire res_ready,
  output wire [2:0] res_chan,
  output wire [`OSA_SAMPLE_W-1:0] res_data
);

  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_PUSH = 2'd3;
  localparam RES_W = `OSA_SAMPLE_W + 3;

  reg [2:0] pins_s1_r;
  reg [2:0] pins_s2_r;
  reg trig_s1_r;
  reg trig_s2_r;
  reg trig_d_r;
  reg [2:0] pins_lat_r;
  reg init_r;
  reg busy_d_r;
  reg [7:0] device_setup_r;
  reg [7:0] oversample_setup_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] lg_r;
  reg ext_r;
  reg [8:0] n_done_r;
  reg [7:0] timer_r;
  reg [2:0] ch_r;
  reg [`OSA_ACC_W-1:0] acc_r [0:`OSA_CHANNELS-1];
  reg [3:0] lg_sel;
  reg [31:0] pad_full;
  reg [7:0] pad_cyc;
  reg [`OSA_ACC_W-1:0] avg_full;
  wire trig_rise;
  wire sw_mode;
  wire ext_sel;
  wire last_sample;
  wire fifo_ready;
  wire fifo_valid;
  wire [RES_W-1:0] fifo_in;
  wire [RES_W-1:0] fifo_out;
  wire [3:0] reg_ratio;
  wire [8:0] ratio_cnt;
  integer i;

  // Pin synchronisers and trigger edge detect
  always @(posedge clk_sys) begin
    if (rst) begin
      pins_s1_r <= 3'h0;
      pins_s2_r <= 3'h0;
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else if (clk_en) begin
      pins_s1_r <= ratio_select_pins;
      pins_s2_r <= pins_s1_r;
      trig_s1_r <= conversion_trigger;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  assign trig_rise = trig_s2_r && !trig_d_r;

  // Pin latch: once after reset, then on each busy fall
  always @(posedge clk_sys) begin
    if (rst) begin
      pins_lat_r <= 3'h0;
      init_r <= 1'b1;
      busy_d_r <= 1'b0;
    end else if (clk_en) begin
      busy_d_r <= busy_r;
      if (init_r && trig_s2_r == trig_d_r) begin
        pins_lat_r <= pins_s2_r;
        init_r <= 1'b0;
      end else if (busy_d_r && !busy_r) begin
        pins_lat_r <= pins_s2_r;
      end
    end
  end

  // Mode decode
  assign sw_mode = (pins_lat_r == `OSA_PINS_SW_MODE);
  assign reg_ratio = oversample_setup_r[`OSA_RATIO_HI:`OSA_RATIO_LO];

  // Oversampling ratio as a power of two
  always @* begin
    lg_sel = 4'h0;
    if (sw_mode) begin
      if (reg_ratio > `OSA_RATIO_LG_MAX) begin
        lg_sel = `OSA_RATIO_LG_MAX;
      end else begin
        lg_sel = reg_ratio;
      end
    end else begin
      lg_sel = {1'b0, pins_lat_r};
    end
  end

  // External sample clock, software mode only and ratio above 1
  assign ext_sel = sw_mode && device_setup_r[`OSA_EXT_CLK_BIT] &&
    (lg_sel != 4'h0);

  // Internal sample clock period from the pad field in software mode, from F0 otherwise
  always @* begin
    pad_full = `OSA_PAD_CYC(`OSA_PAD_F0_HKHZ);
    if (sw_mode) begin
      case (oversample_setup_r[`OSA_PAD_HI:`OSA_PAD_LO])
        3'h0: pad_full = `OSA_PAD_CYC(`OSA_PAD_F0_HKHZ);
        3'h1: pad_full = `OSA_PAD_CYC(`OSA_PAD_F1_HKHZ);
        3'h2: pad_full = `OSA_PAD_CYC(`OSA_PAD_F2_HKHZ);
        3'h3: pad_full = `OSA_PAD_CYC(`OSA_PAD_F3_HKHZ);
        3'h4: pad_full = `OSA_PAD_CYC(`OSA_PAD_F4_HKHZ);
        3'h5: pad_full = `OSA_PAD_CYC(`OSA_PAD_F5_HKHZ);
        3'h6: pad_full = `OSA_PAD_CYC(`OSA_PAD_F6_HKHZ);
        3'h7: pad_full = `OSA_PAD_CYC(`OSA_PAD_F7_HKHZ);
        default: pad_full = `OSA_PAD_CYC(`OSA_PAD_F0_HKHZ);
      endcase
    end
    pad_cyc = pad_full[7:0];
  end

  assign ratio_cnt = 9'h001 << lg_r;
  assign last_sample = (n_done_r == ratio_cnt - 9'h001);

  // Group sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (trig_rise) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          if (last_sample) begin
            state_nxt = ST_PUSH;
          end else begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (ext_r) begin
          if (trig_rise) begin
            state_nxt = ST_CONV;
          end
        end else if (timer_r == 8'h00) begin
          state_nxt = ST_CONV;
        end
      end
      ST_PUSH: begin
        if (fifo_ready && ch_r == 3'h7) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer state, sample counting and busy
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      conv_start_r <= 1'b0;
      lg_r <= 4'h0;
      ext_r <= 1'b0;
      n_done_r <= 9'h000;
      timer_r <= 8'h00;
      ch_r <= 3'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      conv_start_r <= 1'b0;
      if (timer_r != 8'h00) begin
        timer_r <= timer_r - 8'h01;
      end
      case (state_r)
        ST_IDLE: begin
          if (trig_rise) begin
            lg_r <= lg_sel;
            ext_r <= ext_sel;
            n_done_r <= 9'h000;
            ch_r <= 3'h0;
            busy_r <= 1'b1;
            conv_start_r <= 1'b1;
            timer_r <= pad_cyc - 8'h01;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            n_done_r <= n_done_r + 9'h001;
          end
        end
        ST_WAIT: begin
          if ((ext_r && trig_rise) || (!ext_r && timer_r == 8'h00)) begin
            conv_start_r <= 1'b1;
            timer_r <= pad_cyc - 8'h01;
          end
        end
        ST_PUSH: begin
          if (fifo_ready) begin
            ch_r <= ch_r + 3'h1;
            if (ch_r == 3'h7) begin
              busy_r <= 1'b0;
            end
          end
        end
        default: busy_r <= 1'b0;
      endcase
    end
  end

  // Per-channel accumulators of signed samples
  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < `OSA_CHANNELS; i = i + 1) begin
        acc_r[i] <= {`OSA_ACC_W{1'b0}};
      end
    end else if (clk_en) begin
      for (i = 0; i < `OSA_CHANNELS; i = i + 1) begin
        if (state_r == ST_IDLE && trig_rise) begin
          acc_r[i] <= {`OSA_ACC_W{1'b0}};
        end else if (state_r == ST_CONV && conv_done) begin
          acc_r[i] <= acc_r[i] + {{(`OSA_ACC_W-`OSA_SAMPLE_W)
            {conv_data[i*`OSA_SAMPLE_W+`OSA_SAMPLE_W-1]}},
            conv_data[i*`OSA_SAMPLE_W +: `OSA_SAMPLE_W]};
        end
      end
    end
  end

  // Sum divided by the ratio, floor of the signed value
  always @* begin
    avg_full = $signed(acc_r[ch_r]) >>> lg_r;
  end

  assign fifo_in = {ch_r, avg_full[`OSA_SAMPLE_W-1:0]};

  // Result buffer, readable while the group is still busy
  osa_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(state_r == ST_PUSH),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(res_ready),
    .out_data(fifo_out)
  );

  assign res_valid = fifo_valid;
  assign res_chan = fifo_out[RES_W-1:`OSA_SAMPLE_W];
  assign res_data = fifo_out[`OSA_SAMPLE_W-1:0];

  // Register writes
  always @(posedge clk_sys) begin
    if (rst) begin
      device_setup_r <= `OSA_RST_DEVICE_SETUP;
      oversample_setup_r <= `OSA_RST_OVERSAMPLE_SETUP;
    end else if (clk_en && reg_wr_en) begin
      if (reg_addr == `OSA_OFF_DEVICE_SETUP) begin
        device_setup_r <= reg_wdata;
      end
      if (reg_addr == `OSA_OFF_OVERSAMPLE_SETUP) begin
        oversample_setup_r <= reg_wdata;
      end
    end
  end

  // Register reads, one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (clk_en && reg_rd_en) begin
      case (reg_addr)
        `OSA_OFF_DEVICE_SETUP: reg_rdata_r <= device_setup_r;
        `OSA_OFF_OVERSAMPLE_SETUP: reg_rdata_r <= oversample_setup_r;
        `OSA_OFF_FILTER_STATUS: reg_rdata_r <= {busy_r, sw_mode, ext_sel,
          1'b0, lg_sel};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> verification/osa_filter_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "osa_regs.vh"
module osa_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_trigger,
  input wire logic busy_r,
  input wire logic conv_start_r,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`OSA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [2:0] res_chan,
  input wire logic [`OSA_SAMPLE_W-1:0] res_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Write then read of the oversampling setup
  sequence wr_ovs; reg_wr_en && reg_addr == 6'h08; endsequence
  sequence rd_ovs; reg_rd_en && reg_addr == 6'h08; endsequence
  start_busy_a: assert property (conv_start_r |-> busy_r)
    else $error("start without busy");
  start_pulse_a: assert property (conv_start_r |=> !conv_start_r)
    else $error("start longer than one cycle");
  busy_rise_a: assert property ($rose(busy_r) |-> conv_start_r)
    else $error("busy rose without start");
  trig_cause_a: assert property (conv_start_r && !$past(busy_r)
    |-> $past(conversion_trigger, 2)) else $error("start without trigger");
  busy_hold_a: assert property (conv_start_r |=> busy_r [*8])
    else $error("busy fell during conversion");
  hold_res_a: assert property (res_valid && !res_ready
    |=> res_valid && $stable(res_data) && $stable(res_chan))
    else $error("result changed while stalled");
  chan_order_a: assert property (res_valid && res_ready && res_chan != 3'h7 ##1
    res_valid |-> res_chan == $past(res_chan) + 3'h1)
    else $error("channel order broken");
  unmapped_a: assert property (reg_rd_en && reg_addr == 6'h01
    |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
  readback_a: assert property (wr_ovs ##1 rd_ovs
    |=> reg_rdata_r == $past(reg_wdata, 2)) else $error("readback wrong");
endmodule
bind osa_filter osa_props u_props (.clk_sys(clk_sys), .rst(rst),
  .conversion_trigger(conversion_trigger), .busy_r(busy_r),
  .conv_start_r(conv_start_r), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
  .res_valid(res_valid), .res_ready(res_ready), .res_chan(res_chan),
  .res_data(res_data));
`default_nettype wire

// >>> verification/osa_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
module osa_conv_model #(
  parameter int LAT = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_start_r,
  input wire logic busy_r,
  input wire logic [15:0] base,
  output logic conv_done,
  output logic [127:0] conv_data,
  output logic [15:0] n_conv
);
  logic busy_q;
  logic [15:0] idx;
  logic [127:0] smp;
  int tmr = 0;
  // Data only meaningful with done, scrambled otherwise
  assign conv_data = conv_done ? smp : ~smp;
  assign idx = busy_q ? n_conv : 16'h0000;
  // Fixed latency; sample k of a group is base + 3*ch + k
  always @(posedge clk_sys) begin
    busy_q <= busy_r;
    conv_done <= tmr == 1;
    tmr <= tmr > 0 ? tmr - 1 : 0;
    if (rst) begin
      n_conv <= 16'h0000;
      tmr <= 0;
    end else if (conv_start_r) begin
      n_conv <= idx + 16'h0001;
      tmr <= LAT;
      for (int k = 0; k < 8; k++) smp[16*k +: 16] <= base + 16'(3*k) + idx;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, trig = 1'b0, rd = 1'b0, wr = 1'b0;
  logic res_ready = 1'b0, hold = 1'b0, busy, start, done, res_valid;
  logic [2:0] pins = 3'h0, res_chan;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00, rdata;
  logic [127:0] cdata;
  logic [15:0] res_data, n_conv;
  logic signed [15:0] base = 16'h0000;
  logic [18:0] expq[$];
  int err_total = 0, tests_run = 0, seed = 32'h395AF7D7, cyc = 0;
  osa_filter dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
    .ratio_select_pins(pins), .conversion_trigger(trig), .busy_r(busy),
    .conv_start_r(start), .conv_done(done), .conv_data(cdata),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_r(rdata), .res_valid(res_valid), .res_ready(res_ready),
    .res_chan(res_chan), .res_data(res_data));
  osa_conv_model cm (.clk_sys(clk_sys), .rst(rst), .conv_start_r(start),
    .busy_r(busy), .base(base), .conv_done(done), .conv_data(cdata),
    .n_conv(n_conv));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [18:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      end_sim;
    end
  end
  // Consumer with random stalls; checks each result taken
  always @(posedge clk_sys) begin
    if (res_valid && res_ready)
      chk("result", expq.pop_front(), {res_chan, res_data});
    #1 res_ready = !hold && ($random(seed) % 3 != 0);
  end
  // Expected averaged word of a channel
  function automatic logic [18:0] avg(input int k, n);
    return {3'(k), 16'(base + 3 * k + (n - 1) / 2)};
  endfunction
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_sys);
    #1 wr = 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(posedge clk_sys);
    #1 rd = 1'b0;
    chk("register", {11'h000, e}, {11'h000, rdata});
  endtask
  // One group of n samples, spaced p cycles, external clock if ext
  task automatic grp(input int n, p, input bit ext);
    int t0, lim, i;
    bit st;
    // Stalled only once the held results fill the buffer
    st = hold && expq.size() >= 16;
    lim = (n - 1) * p + 45 + (st ? 300 : 0);
    base = 16'($random(seed) % 4096);
    for (i = 0; i < 8; i++) expq.push_back(avg(i, n));
    t0 = cyc;
    trig = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 trig = 1'b0;
    for (i = 1; i < n && ext; i++) begin
      repeat (p - 10) @(posedge clk_sys);
      #1 trig = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 trig = 1'b0;
    end
    for (i = 0; busy !== 1'b0 && i < 40000; i++) begin
      if (st && i == (n - 1) * p + 300) begin
        chk("stalled busy", 19'h1, {18'h0, busy});
        hold = 1'b0;
      end
      @(posedge clk_sys);
    end
    #1 chk("conversions", 19'(n), {3'h0, n_conv});
    chk("busy time", 19'h1, 19'(cyc - t0 >= lim - 65 && cyc - t0 <= lim));
    $display("group of %0d ended after %0d cycles", n, cyc - t0);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 rreg(6'h02, 8'h00);
    rreg(6'h08, 8'h00);
    rreg(6'h01, 8'h00);
    wreg(6'h08, 8'h08);
    hold = 1'b1;
    // Pins set now are latched as this group's busy falls
    for (int c = 0; c < 7; c++) begin
      pins = 3'(c + 1);
      grp(1 << c, 125, 1'b0);
    end
    grp(256, 125, 1'b0);
    wreg(6'h08, 8'hE7);
    rreg(6'h08, 8'hE7);
    grp(128, 179, 1'b0);
    wreg(6'h08, 8'h02);
    wreg(6'h02, 8'h20);
    grp(4, 300, 1'b1);
    repeat (40) @(posedge clk_sys);
    #1 chk("left over", 19'h0, 19'(expq.size()));
    end_sim;
  end
endmodule
`default_nettype wire
